// *** logic/art_pkg.sv ***
// constants and register map of the pwm auto-reload timer
//
// Summary of operation
// [RQ1] 8-bit counter steps on prescaler tick
// [RQ2] overflow reloads counter, prescaler untouched
// [RQ3] prescaler divides input by two-power select
// [RQ4] run enable clear freezes prescaler, counter
// [RQ5] reset clears counter, prescaler, selects cpu
// [RQ6] force reload loads counter, clears prescaler; here only when the same CSR write also sets TCE
// [RQ7] counter writable live; write clears prescaler
// [RQ8] hidden compares reload from duty at overflow
// [RQ9] each pwm output has own enable
// [RQ10] period is 256 minus reload counts
// [RQ11] overflow sets outputs to polarity level
// [RQ12] compare match returns output other level
// [RQ13] software sets duty above reload value
// [RQ14] pwm halts while processor halted
// [RQ15] overflow sets flag, optional interrupt
// [RQ16] event mode flags after 256-reload events
// [RQ17] software stops counter before halt
// [RQ18] selected edge captures counter, sets flag
// [RQ19] capture locked until register read
// [RQ20] capture interrupt pending while flag set
// [RQ21] capture edges wake processor from halt
// [RQ22] timer interrupts wake from wait, halt
// [RQ23] status read clears overflow flag
// [RQ24] clock source 0 cpu, 1 external
// [RQ25] polarity 0 high at or below compare
// [RQ26] edge select 0 falling, 1 rising
// [RQ27] external inputs synchronised, edge detected
`default_nettype none
package art_pkg;
  localparam logic [7:0] ART_DUTY3_OFS = 8'h73;
  localparam logic [7:0] ART_DUTY2_OFS = 8'h74;
  localparam logic [7:0] ART_DUTY1_OFS = 8'h75;
  localparam logic [7:0] ART_DUTY0_OFS = 8'h76;
  localparam logic [7:0] ART_PWMCTRL_OFS = 8'h77;
  localparam logic [7:0] ART_CSR_OFS = 8'h78;
  localparam logic [7:0] ART_CNT_OFS = 8'h79;
  localparam logic [7:0] ART_ARR_OFS = 8'h7A;
  localparam logic [7:0] ART_CAPCSR_OFS = 8'h7B;
  localparam logic [7:0] ART_CAP1_OFS = 8'h7C;
  localparam logic [7:0] ART_CAP2_OFS = 8'h7D;
  localparam logic [7:0] ART_HALT_OFS = 8'h7E;
  localparam int ART_CSR_EXT_CLOCK_SELECT = 7;
  localparam int ART_CSR_CC_LSB = 4;
  localparam int ART_CSR_TCE = 3;
  localparam int ART_CSR_FORCE_RELOAD = 2;
  localparam int ART_CSR_OIE = 1;
  localparam int ART_CSR_OVF = 0;
  localparam int ART_PWM_OE_LSB = 4;
  localparam int ART_CAP_CS_LSB = 4;
  localparam int ART_CAP_CIE_LSB = 2;
  localparam int ART_CAP_CF_LSB = 0;
  localparam logic [7:0] ART_RESET_BYTE = 8'h00;
  localparam logic [6:0] ART_PRESC_RESET = 7'h00;
  localparam logic [1:0] ART_HRESP_OKAY = 2'h0;
  localparam logic [1:0] ART_HTRANS_NONSEQ = 2'h2;
endpackage : art_pkg
`default_nettype wire

// *** logic/art_timer.sv ***
// pwm auto-reload timer with ahb-lite register slave
//
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module art_timer import art_pkg::*; #(
  parameter int NUM_PWM = 4,
  parameter int NUM_CAP = 2
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic externalEventClock,
  input wire logic [NUM_CAP-1:0] captureInputPin,
  input wire logic cpuHalt,
  output logic [NUM_PWM-1:0] pwmOut,
  output logic [NUM_PWM-1:0] pwmOutEnable,
  output logic overflowIrq,
  output logic [NUM_CAP-1:0] captureIrq,
  output logic wakeUp
);
  // only four pwm and two capture slices are wired into the map
  if (NUM_PWM != 4 || NUM_CAP != 2) begin : gBadParams
    $error("art_timer supports four pwm and two capture channels only");
  end

  // ahb-lite address phase capture
  logic wrPend_q, rdPend_q;
  logic [7:0] addrPend_q;
  logic addrOk;
  assign addrOk = hsel && hready && htrans == ART_HTRANS_NONSEQ;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addrPend_q <= ART_RESET_BYTE;
    end else begin
      wrPend_q <= addrOk && hwrite;
      rdPend_q <= addrOk && !hwrite;
      // register index sits in the word address bits
      addrPend_q <= haddr[9:2];
    end
  end

  // write strobes, data phase
  logic wrCsr, wrCnt, wrArr, wrPwm, wrCap, wrHalt;
  logic [NUM_PWM-1:0] wrDuty;
  logic [7:0] wb;
  assign wb = hwdata[7:0];
  assign wrCsr = wrPend_q && addrPend_q == ART_CSR_OFS;
  assign wrCnt = wrPend_q && addrPend_q == ART_CNT_OFS;
  assign wrArr = wrPend_q && addrPend_q == ART_ARR_OFS;
  assign wrPwm = wrPend_q && addrPend_q == ART_PWMCTRL_OFS;
  assign wrCap = wrPend_q && addrPend_q == ART_CAPCSR_OFS;
  assign wrHalt = wrPend_q && addrPend_q == ART_HALT_OFS;
  assign wrDuty[0] = wrPend_q && addrPend_q == ART_DUTY0_OFS;
  assign wrDuty[1] = wrPend_q && addrPend_q == ART_DUTY1_OFS;
  assign wrDuty[2] = wrPend_q && addrPend_q == ART_DUTY2_OFS;
  assign wrDuty[3] = wrPend_q && addrPend_q == ART_DUTY3_OFS;
  // read side effects fire in the address phase so data can be registered
  logic rdCsrNow;
  logic [NUM_CAP-1:0] rdCapNow;
  assign rdCsrNow = addrOk && !hwrite && haddr[9:2] == ART_CSR_OFS;
  assign rdCapNow[0] = addrOk && !hwrite && haddr[9:2] == ART_CAP1_OFS;
  assign rdCapNow[1] = addrOk && !hwrite && haddr[9:2] == ART_CAP2_OFS;

  // control registers
  logic extSel_q, runEn_q, ovfIe_q, haltSw_q;
  logic [2:0] prescSel_q;
  logic [7:0] reload_q;
  logic [NUM_PWM-1:0] oe_q, pol_q;
  logic [NUM_CAP-1:0] edgeSel_q, capIe_q;
  logic [7:0] duty_q [NUM_PWM];
  logic forceLoad;
  // [RQ6] force reload strobe
  assign forceLoad = wrCsr && wb[ART_CSR_FORCE_RELOAD] && wb[ART_CSR_TCE];
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      // [RQ5] cpu clock after reset
      extSel_q <= 1'b0;
      prescSel_q <= 3'h0;
      runEn_q <= 1'b0;
      ovfIe_q <= 1'b0;
      reload_q <= ART_RESET_BYTE;
      oe_q <= '0;
      pol_q <= '0;
      edgeSel_q <= '0;
      capIe_q <= '0;
      haltSw_q <= 1'b0;
    end else begin
      if (wrCsr) begin
        // [RQ24] source select bit
        extSel_q <= wb[ART_CSR_EXT_CLOCK_SELECT];
        prescSel_q <= wb[ART_CSR_CC_LSB +: 3];
        runEn_q <= wb[ART_CSR_TCE];
        ovfIe_q <= wb[ART_CSR_OIE];
      end
      if (wrArr) begin
        reload_q <= wb;
      end
      if (wrPwm) begin
        oe_q <= wb[ART_PWM_OE_LSB +: NUM_PWM];
        pol_q <= wb[NUM_PWM-1:0];
      end
      if (wrCap) begin
        edgeSel_q <= wb[ART_CAP_CS_LSB +: NUM_CAP];
        capIe_q <= wb[ART_CAP_CIE_LSB +: NUM_CAP];
      end
      if (wrHalt) begin
        haltSw_q <= wb[0];
      end
    end
  end

  // [RQ27] input synchronisers
  logic [NUM_CAP:0] syncA_q, syncB_q, syncC_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      syncA_q <= '0;
      syncB_q <= '0;
      syncC_q <= '0;
    end else begin
      syncA_q <= {captureInputPin, externalEventClock};
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end
  logic extRise;
  assign extRise = syncB_q[0] && !syncC_q[0];

  // prescaler and counter
  logic halted;
  assign halted = cpuHalt || haltSw_q;
  logic [6:0] presc_q;
  logic [7:0] count_q;
  logic inputTick, presTick, ovf;
  logic [7:0] prescDiv;
  // [RQ24] cpu clock or external edges
  assign inputTick = extSel_q ? extRise : 1'b1;
  // [RQ3] power of two tap
  assign prescDiv = 8'h01 << prescSel_q;
  // [RQ4] frozen unless enabled; [RQ14] halted stops pwm
  assign presTick = runEn_q && !halted && inputTick
    && ({1'b0, presc_q} == prescDiv - 8'h01);
  assign ovf = presTick && count_q == 8'hFF;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      presc_q <= ART_PRESC_RESET;
    end else if (forceLoad || wrCnt) begin
      // [RQ7] load clears prescaler
      presc_q <= ART_PRESC_RESET;
    end else if (runEn_q && !halted && inputTick) begin
      presc_q <= presTick ? ART_PRESC_RESET : presc_q + 7'h01;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= ART_RESET_BYTE;
    end else if (wrCnt) begin
      count_q <= wb;
    end else if (forceLoad) begin
      count_q <= reload_q;
    end else if (ovf) begin
      // [RQ2] reload on overflow; [RQ10] period 256 minus reload
      count_q <= reload_q;
    end else if (presTick) begin
      // [RQ1] count up
      count_q <= count_q + 8'h01;
    end
  end

  // [RQ15] overflow flag; [RQ16] same path counts events
  logic ovfFlag_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ovfFlag_q <= 1'b0;
    end else if (ovf) begin
      ovfFlag_q <= 1'b1;
    end else if (rdCsrNow) begin
      // [RQ23] read clears flag
      ovfFlag_q <= 1'b0;
    end
  end

  // pwm channels
  logic [7:0] cmp_q [NUM_PWM];
  logic [NUM_PWM-1:0] rawLevel_q;
  genvar g;
  generate
    for (g = 0; g < NUM_PWM; g++) begin : gPwm
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          duty_q[g] <= ART_RESET_BYTE;
          cmp_q[g] <= ART_RESET_BYTE;
          rawLevel_q[g] <= 1'b0;
        end else begin
          if (wrDuty[g]) begin
            duty_q[g] <= wb;
          end
          // [RQ8] shadow load at overflow
          if (ovf) begin
            cmp_q[g] <= duty_q[g];
          end
          // raw level 1 while counter at or below compare
          if (ovf) begin
            // [RQ11] overflow starts period
            rawLevel_q[g] <= 1'b1;
          end else if (presTick && count_q == cmp_q[g]) begin
            // [RQ12] compare match restores
            rawLevel_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  // [RQ25] polarity applied on output flop, next cycle
  // [RQ9] per channel enable
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pwmOut <= '0;
      pwmOutEnable <= '0;
    end else begin
      pwmOut <= oe_q & (rawLevel_q ^ pol_q);
      pwmOutEnable <= oe_q;
    end
  end

  // capture channels
  logic [NUM_CAP-1:0] capFlag_q;
  logic [7:0] capVal_q [NUM_CAP];
  generate
    for (g = 0; g < NUM_CAP; g++) begin : gCap
      logic edgeHit;
      // [RQ26] edge select; [RQ27] edge detect on synced copy
      assign edgeHit = edgeSel_q[g] ? (syncB_q[g+1] && !syncC_q[g+1])
                                    : (!syncB_q[g+1] && syncC_q[g+1]);
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          capFlag_q[g] <= 1'b0;
          capVal_q[g] <= ART_RESET_BYTE;
        end else if (edgeHit && !capFlag_q[g]) begin
          // [RQ18] latch counter; [RQ19] locked while flagged
          capVal_q[g] <= count_q;
          capFlag_q[g] <= 1'b1;
        end else if (rdCapNow[g]) begin
          // [RQ19] read unlocks
          capFlag_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // interrupts and wake
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      overflowIrq <= 1'b0;
      captureIrq <= '0;
      wakeUp <= 1'b0;
    end else begin
      overflowIrq <= ovfFlag_q && ovfIe_q;
      // [RQ20] pending while flag set
      captureIrq <= capFlag_q & capIe_q;
      // [RQ21] capture wakes halt; [RQ22] any request wakes
      wakeUp <= (ovfFlag_q && ovfIe_q) || |(capFlag_q & capIe_q);
    end
  end

  // read data registered in address phase
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    case (haddr[9:2])
      ART_DUTY0_OFS: rdByte = duty_q[0];
      ART_DUTY1_OFS: rdByte = duty_q[1];
      ART_DUTY2_OFS: rdByte = duty_q[2];
      ART_DUTY3_OFS: rdByte = duty_q[3];
      ART_PWMCTRL_OFS: rdByte = {oe_q, pol_q};
      ART_CSR_OFS: rdByte = {extSel_q, prescSel_q, runEn_q, 1'b0, ovfIe_q, ovfFlag_q};
      ART_CNT_OFS: rdByte = count_q;
      ART_ARR_OFS: rdByte = reload_q;
      ART_CAPCSR_OFS: rdByte = {2'b00, edgeSel_q, capIe_q, capFlag_q};
      ART_CAP1_OFS: rdByte = capVal_q[0];
      ART_CAP2_OFS: rdByte = capVal_q[1];
      ART_HALT_OFS: rdByte = {7'h00, haltSw_q};
      default: rdByte = 8'h00;
    endcase
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= ART_HRESP_OKAY;
    end else begin
      hrdata <= (addrOk && !hwrite) ? {24'h000000, rdByte} : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= ART_HRESP_OKAY;
    end
  end

  // [RQ2] overflow leaves counter at reload next cycle
  overflow_reload_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ2]
    ovf && !wrCnt && !forceLoad |=> count_q == $past(reload_q))
    else $error("counter not reloaded at overflow");
  // [RQ4] disabled counter frozen
  freeze_counter_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ4]
    !runEn_q && !wrCnt && !forceLoad |=> $stable(count_q) && $stable(presc_q))
    else $error("counter moved while disabled");
  // [RQ7] counter write clears prescaler
  write_clears_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ7]
    wrCnt |=> count_q == $past(wb) && presc_q == 7'h00)
    else $error("counter write not applied");
  // [RQ15] flag set after overflow
  ovf_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ15]
    ovf |=> ovfFlag_q)
    else $error("overflow flag missing");
  // [RQ23] read clears flag
  ovf_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ23]
    rdCsrNow && !ovf |=> !ovfFlag_q)
    else $error("overflow flag not cleared by read");
  // [RQ19] capture value held while flagged
  cap_lock_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ19]
    capFlag_q[0] |=> $stable(capVal_q[0]))
    else $error("capture overwritten while locked");
  // [RQ8] compare loads at overflow only
  cmp_shadow_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ8]
    !ovf |=> $stable(cmp_q[0]))
    else $error("compare changed outside overflow");
  // [RQ11] output after overflow follows polarity
  pwm_level_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ11]
    ovf && oe_q[0] && $stable(pol_q) ##1 $stable(oe_q) && $stable(pol_q)
      |=> pwmOut[0] == !pol_q[0])
    else $error("pwm level wrong after overflow");
  // [RQ20] irq follows flag
  cap_irq_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ20]
    capFlag_q[1] && capIe_q[1] |=> captureIrq[1])
    else $error("capture irq not pending");
  // [RQ1] tick steps counter
  count_up_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ1]
    presTick && !ovf && !wrCnt && !forceLoad |=> count_q == $past(count_q) + 8'h01)
    else $error("counter did not step on tick");
  // [RQ6] force reload restarts
  force_reload_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ6]
    forceLoad && !wrCnt |=> count_q == $past(reload_q) && presc_q == ART_PRESC_RESET)
    else $error("force reload not applied");
  // [RQ9] disabled channel quiet
  pwm_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ9]
    !oe_q[1] |=> !pwmOut[1] && !pwmOutEnable[1])
    else $error("disabled pwm channel driving");
  // [RQ12] match ends pulse
  match_low_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ12]
    presTick && !ovf && count_q == cmp_q[1] |=> !rawLevel_q[1])
    else $error("compare match did not restore level");
  // [RQ14] halt freezes counter
  halt_freeze_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ14]
    halted && !wrCnt && !forceLoad |=> $stable(count_q) && $stable(presc_q))
    else $error("counter moved while halted");
  // [RQ15] flag drives irq
  ovf_irq_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ15]
    ovfFlag_q && ovfIe_q |=> overflowIrq)
    else $error("overflow irq not raised");
  // [RQ18] capture takes counter
  cap_take_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ18]
    $rose(capFlag_q[0]) |-> capVal_q[0] == $past(count_q))
    else $error("capture value not the counter");
  // [RQ19] read unlocks capture
  cap_unlock_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ19]
    rdCapNow[0] && capFlag_q[0] |=> !capFlag_q[0])
    else $error("capture flag not cleared by read");
  // [RQ24] external mode ignores cpu clock
  ext_tick_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ24]
    extSel_q && !extRise |-> !presTick)
    else $error("counter ticked without external edge");
endmodule : art_timer
`default_nettype wire

// *** tb/art_pin_model.sv ***
// pin-side model: external event clock and capture inputs
`timescale 1ns/1ps
`default_nettype none
module art_pin_model (
  input wire logic clk_sys,
  output logic extClk,
  output logic [1:0] capPin
);
  // event clock idles low between bursts, never free-running
  initial begin
    extClk = 1'b0;
    capPin = 2'h0;
  end
  // slow edges, well below half the system clock rate
  task automatic pulse();
    repeat (4) @(posedge clk_sys);
    extClk <= 1'b1;
    repeat (4) @(posedge clk_sys);
    extClk <= 1'b0;
  endtask : pulse
  // one level change, then room for the input synchroniser
  task automatic drive(input int ch, input logic v);
    @(posedge clk_sys);
    capPin[ch] <= v;
    repeat (6) @(posedge clk_sys);
  endtask : drive
endmodule : art_pin_model
`default_nettype wire

// *** tb/art_timer_tb_top.sv ***
// self-checking bench for the pwm auto-reload timer
`timescale 1ns/1ps
`default_nettype none
module art_timer_tb_top import art_pkg::*;;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic cpuHalt = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [1:0] hresp;
  logic externalEventClock;
  logic [1:0] captureInputPin;
  logic [3:0] pwmOut;
  logic [3:0] pwmOutEnable;
  logic overflowIrq;
  logic [1:0] captureIrq;
  logic wakeUp;
  int errors = 0;
  int compares = 0;

  always #12.5 clk_sys = ~clk_sys;

  art_timer i_art_timer (
    .clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .externalEventClock,
    .captureInputPin, .cpuHalt, .pwmOut, .pwmOutEnable, .overflowIrq,
    .captureIrq, .wakeUp
  );
  art_pin_model i_art_pin_model (
    .clk_sys(clk_sys),
    .extClk(externalEventClock),
    .capPin(captureInputPin)
  );

  task automatic conclude(input bit hung);
    if (hung) begin
      errors++;
      $display("MISMATCH %0t wait limit used up", $time);
    end
    $display("compares %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic waitReady();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) begin
      @(posedge clk_sys);
      n++;
      if (n > 50) conclude(1'b1);
    end
  endtask : waitReady

  task automatic waitWake();
    int n;
    n = 0;
    while (wakeUp !== 1'b1) begin
      @(posedge clk_sys);
      n++;
      if (n > 400) conclude(1'b1);
    end
  endtask : waitWake

  // single non-pipelined transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    // byte address is four times the register index
    haddr <= {22'h000000, a, 2'b00};
    hwrite <= wr;
    htrans <= ART_HTRANS_NONSEQ;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    waitReady();
    q = hrdata;
  endtask : bus

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : w

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h000000, e});
    chk(32'(hresp), 32'(ART_HRESP_OKAY));
  endtask : rc

  // one full period window gives the high time whatever the phase
  task automatic highs(input int ch, input int win, output int hi);
    hi = 0;
    repeat (win) begin
      @(posedge clk_sys);
      hi += int'(pwmOut[ch] === 1'b1);
    end
  endtask : highs

  task automatic tReset();
    for (int a = 8'h73; a <= 8'h7D; a++) begin
      rc(8'(a), 8'h00);
    end
    w(8'h40, 8'hFF);
    rc(8'h40, 8'h00);
    chk(32'({pwmOut, pwmOutEnable, overflowIrq, captureIrq, wakeUp}), 32'h0);
    $display("done reset values");
  endtask : tReset

  task automatic tCount();
    w(ART_CSR_OFS, 8'h70);
    w(ART_CNT_OFS, 8'h55);
    repeat (20) @(posedge clk_sys);
    rc(ART_CNT_OFS, 8'h55);
    w(ART_CSR_OFS, 8'h78);
    w(ART_CNT_OFS, 8'h10);
    repeat (100) @(posedge clk_sys);
    rc(ART_CNT_OFS, 8'h10);
    repeat (40) @(posedge clk_sys);
    rc(ART_CNT_OFS, 8'h11);
    $display("done counting");
  endtask : tCount

  task automatic tOverflow();
    w(ART_ARR_OFS, 8'hF0);
    w(ART_CNT_OFS, 8'hFF);
    w(ART_CSR_OFS, 8'h7A);
    waitWake();
    chk(32'(overflowIrq), 32'h1);
    rc(ART_CSR_OFS, 8'h7B);
    rc(ART_CSR_OFS, 8'h7A);
    rc(ART_CNT_OFS, 8'hF0);
    $display("done overflow");
  endtask : tOverflow

  task automatic tForce();
    w(ART_CSR_OFS, 8'h70);
    w(ART_CNT_OFS, 8'h33);
    w(ART_CSR_OFS, 8'h7C);
    rc(ART_CNT_OFS, 8'hF0);
    rc(ART_CSR_OFS, 8'h78);
    $display("done force reload");
  endtask : tForce

  task automatic tPwm();
    int hi;
    logic [3:0] held;
    w(ART_CSR_OFS, 8'h08);
    w(ART_ARR_OFS, 8'h00);
    w(ART_PWMCTRL_OFS, 8'hF5);
    for (int c = 0; c < 4; c++) begin
      w(ART_DUTY0_OFS - 8'(c), 8'(8'h20 + 8'h40 * c));
    end
    repeat (600) @(posedge clk_sys);
    chk(32'(pwmOutEnable), 32'hF);
    for (int c = 0; c < 4; c++) begin
      highs(c, 256, hi);
      chk(32'(hi), 32'(c % 2 == 0 ? 223 - 64 * c : 33 + 64 * c));
    end
    cpuHalt <= 1'b1;
    repeat (3) @(posedge clk_sys);
    held = pwmOut;
    repeat (300) @(posedge clk_sys);
    chk(32'(pwmOut), 32'(held));
    cpuHalt <= 1'b0;
    w(ART_HALT_OFS, 8'h01);
    rc(ART_HALT_OFS, 8'h01);
    held = pwmOut;
    repeat (300) @(posedge clk_sys);
    chk(32'(pwmOut), 32'(held));
    w(ART_HALT_OFS, 8'h00);
    w(ART_ARR_OFS, 8'hC0);
    repeat (300) @(posedge clk_sys);
    highs(3, 64, hi);
    chk(32'(hi), 32'h21);
    w(ART_PWMCTRL_OFS, 8'h05);
    repeat (2) @(posedge clk_sys);
    chk(32'({pwmOut, pwmOutEnable}), 32'h0);
    $display("done pwm");
  endtask : tPwm

  task automatic tCapture();
    w(ART_CSR_OFS, 8'h00);
    w(ART_CNT_OFS, 8'h42);
    w(ART_CAPCSR_OFS, 8'h1C);
    i_art_pin_model.drive(1, 1'b1);
    chk(32'(captureIrq), 32'h0);
    i_art_pin_model.drive(0, 1'b1);
    waitWake();
    chk(32'(captureIrq), 32'h1);
    w(ART_CNT_OFS, 8'h43);
    i_art_pin_model.drive(0, 1'b0);
    i_art_pin_model.drive(0, 1'b1);
    rc(ART_CAPCSR_OFS, 8'h1D);
    rc(ART_CAP1_OFS, 8'h42);
    rc(ART_CAPCSR_OFS, 8'h1C);
    i_art_pin_model.drive(1, 1'b0);
    chk(32'(captureIrq), 32'h2);
    rc(ART_CAP2_OFS, 8'h43);
    $display("done capture");
  endtask : tCapture

  task automatic tEvent();
    logic [31:0] q;
    w(ART_CSR_OFS, 8'h00);
    w(ART_ARR_OFS, 8'hFD);
    w(ART_CNT_OFS, 8'hFD);
    w(ART_CSR_OFS, 8'h8A);
    bus(1'b0, ART_CSR_OFS, 8'h00, q);
    repeat (2) i_art_pin_model.pulse();
    repeat (6) @(posedge clk_sys);
    chk(32'(overflowIrq), 32'h0);
    i_art_pin_model.pulse();
    waitWake();
    chk(32'(overflowIrq), 32'h1);
    w(ART_CSR_OFS, 8'h82);
    cpuHalt <= 1'b1;
    i_art_pin_model.pulse();
    repeat (6) @(posedge clk_sys);
    rc(ART_CNT_OFS, 8'hFD);
    cpuHalt <= 1'b0;
    $display("done event count");
  endtask : tEvent

  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    tReset();
    tCount();
    tOverflow();
    tForce();
    tPwm();
    tCapture();
    tEvent();
    conclude(1'b0);
  end

  initial begin
    #2000000;
    conclude(1'b1);
  end
endmodule : art_timer_tb_top
`default_nettype wire
